/* File: tef_event_flags.sv */
// timer event flag register with mask, interrupt and capture read-back
//
// Function
// - registers take 8-, 16- and 32-bit accesses via byte enables
// - enable-protected registers ignore writes while the timer is enabled
// - match/capture flag sets one count cycle after match or capture
// - writing one clears a match/capture flag; zero leaves it
// - in capture mode, reading the capture value clears its flag
// - unrecoverable fault flag sets one count cycle after the fault
// - writing one clears an unrecoverable fault flag; zero leaves it
// - recoverable fault B flag sets one count cycle after fault B
// - writing one clears recoverable fault B flag; zero leaves it
// - recoverable fault A flag sets one count cycle after fault A
// - overflow mask bit gates the overflow interrupt; zero disables it
//
// register map, byte offsets
//   0x00 control, bit 1 is the timer enable
//   0x04 capture mode, one bit per channel, writable only while disabled
//   0x24 interrupt mask, same layout as the event flags
//   0x2C event flags, write one to clear
//   0x44 + 4*n capture value of channel n, read only
//
// timing
//   an event high at edge c0 shows in the flag register after c0
//   a read strobe at c0 returns its data after c0, for one cycle only
//   the interrupt follows the flags one cycle later
//   a set and a clear of one flag in one cycle leave the flag set
//   unmapped reads return zero, unmapped writes are dropped
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module tef_event_flags #(
	parameter int CH = tef_pkg::CH_N,
	parameter int CW = tef_pkg::CAPT_W
) (
	// clock and reset
	input  wire logic                     i_core_clk,
	input  wire logic                     i_rst,
	// register port
	input  wire logic [tef_pkg::ADDR_W-1:0] i_bus_addr,
	input  wire logic [31:0]              i_bus_wdata,
	input  wire logic [3:0]               i_bus_be,
	input  wire logic                     i_bus_wr,
	input  wire logic                     i_bus_rd,
	output logic [31:0]                   o_bus_rdata,
	// counter events
	input  wire logic                     i_overflow_evt,
	input  wire logic                     i_retrigger_evt,
	input  wire logic                     i_count_evt,
	input  wire logic                     i_err_evt,
	input  wire logic                     i_upd_fault_evt,
	input  wire logic                     i_dbg_fault_evt,
	// fault events
	input  wire logic                     i_flt_a_evt,
	input  wire logic                     i_flt_b_evt,
	input  wire logic [1:0]               i_nrf_evt,
	// channel events
	input  wire logic [CH-1:0]            i_cmp_match,
	input  wire logic [CH-1:0]            i_capt_valid,
	input  wire logic [CH*CW-1:0]         i_capt_data,
	// status outputs
	output logic                          o_enable,
	output logic [CH-1:0]                 o_capt_mode,
	output logic                          o_irq
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic        en_r;
		logic [3:0]  capt_mode_r;
		logic [31:0] mask_r;
		logic [31:0] rdata_r;
		logic        irq_r;
	} tef_top_st_t;

	tef_top_st_t st_r;
	tef_top_st_t st_nxt;

	// flag bank link
	tef_flag_if #(.N(32)) flag_if ();

	// capture values
	logic [CH*CW-1:0] capt_value;

	// decode helpers
	logic             wr_flags;
	logic             rd_capt;
	logic [7:0]       capt_idx;
	logic [31:0]      wmask;
	logic [31:0]      set_vec;
	logic [31:0]      clr_vec;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------

	// true when an address falls in the capture value window
	function automatic logic capt_hit(input logic [7:0] a);
		logic [7:0] off;
		off = a - tef_pkg::ADDR_CAPT_BASE;
		capt_hit = (a >= tef_pkg::ADDR_CAPT_BASE) && (off[1:0] == 2'b00) &&
			(off[7:2] < 6'(CH));
	endfunction

	// word index of a capture address
	function automatic logic [7:0] capt_index(input logic [7:0] a);
		logic [7:0] off;
		off = a - tef_pkg::ADDR_CAPT_BASE;
		capt_index = {2'b00, off[7:2]};
	endfunction

	// write strobe aimed at one register
	function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] reg_a);
		wr_hit = wr && (a == reg_a);
	endfunction

	// control register image, only the enable bit is kept
	function automatic logic [31:0] ctrl_word(input logic en);
		ctrl_word = {30'h0, en, 1'b0} & tef_pkg::CTRL_VALID;
	endfunction

	// capture mode register image, one bit per channel
	function automatic logic [31:0] mode_word(input logic [3:0] m);
		mode_word = {28'h0, m} & tef_pkg::CAPT_MODE_VALID;
	endfunction

	// ------------------------------------------------------------
	// sub-blocks
	// ------------------------------------------------------------

	// sticky flags
	tef_flag_bank #(
		.VALID (tef_pkg::FLAG_VALID)
	) u_flags (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.fl         (flag_if.bank)
	);

	// capture value holding registers
	tef_capt_store #(
		.CH (CH),
		.CW (CW)
	) u_capt (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_valid    (i_capt_valid),
		.i_data     (i_capt_data),
		.o_value    (capt_value)
	);

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------

	// byte lanes of the current write
	assign wmask    = tef_pkg::lane_mask(i_bus_be);
	assign wr_flags = wr_hit(i_bus_wr, i_bus_addr, tef_pkg::ADDR_FLAGS);
	assign rd_capt  = i_bus_rd && capt_hit(i_bus_addr);
	assign capt_idx = capt_index(i_bus_addr);

	// ------------------------------------------------------------
	// flag set sources, registered in the bank
	// ------------------------------------------------------------
	always_comb begin
		set_vec = '0;
		set_vec[tef_pkg::BIT_OVERFLOW] = i_overflow_evt;
		set_vec[tef_pkg::BIT_RETRIGGER] = i_retrigger_evt;
		set_vec[tef_pkg::BIT_COUNT] = i_count_evt;
		set_vec[tef_pkg::BIT_ERR] = i_err_evt;
		set_vec[tef_pkg::BIT_UPD_FAULT] = i_upd_fault_evt;
		set_vec[tef_pkg::BIT_DBG_FAULT] = i_dbg_fault_evt;
		set_vec[tef_pkg::BIT_FLT_A] = i_flt_a_evt;
		set_vec[tef_pkg::BIT_FLT_B] = i_flt_b_evt;
		set_vec[tef_pkg::NRF_LSB +: tef_pkg::NRF_N] = i_nrf_evt;
		set_vec[tef_pkg::MC_LSB +: CH] = i_cmp_match | i_capt_valid;
	end

	// ------------------------------------------------------------
	// flag clear sources
	// ------------------------------------------------------------
	always_comb begin
		clr_vec = '0;
		// write one clears, zero and unselected lanes leave the flag
		if (wr_flags) begin
			clr_vec = i_bus_wdata & wmask & tef_pkg::FLAG_VALID;
		end
		// reading a capture value clears the channel flag in capture mode
		if (rd_capt && st_r.capt_mode_r[capt_idx[1:0]]) begin
			clr_vec[tef_pkg::MC_LSB + 32'(capt_idx[1:0])] = 1'b1;
		end
	end

	assign flag_if.set = set_vec;
	assign flag_if.clr = clr_vec;

	// ------------------------------------------------------------
	// register writes, read mux and interrupt
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] ctrl_v;
		logic [31:0] mode_v;
		logic [31:0] mask_v;
		ctrl_v = '0;
		mode_v = '0;
		mask_v = '0;
		st_nxt = st_r;

		// control register, enable bit
		if (wr_hit(i_bus_wr, i_bus_addr, tef_pkg::ADDR_CTRL)) begin
			ctrl_v = tef_pkg::lane_merge(ctrl_word(st_r.en_r), i_bus_wdata, i_bus_be);
			st_nxt.en_r = ctrl_v[tef_pkg::BIT_ENABLE];
		end

		// capture mode is enable-protected
		if (wr_hit(i_bus_wr, i_bus_addr, tef_pkg::ADDR_CAPT_MODE) && !st_r.en_r) begin
			mode_v = tef_pkg::lane_merge(mode_word(st_r.capt_mode_r), i_bus_wdata, i_bus_be);
			st_nxt.capt_mode_r = mode_v[3:0];
		end

		// interrupt mask
		if (wr_hit(i_bus_wr, i_bus_addr, tef_pkg::ADDR_INT_MASK)) begin
			mask_v = tef_pkg::lane_merge(st_r.mask_r, i_bus_wdata, i_bus_be);
			st_nxt.mask_r = mask_v & tef_pkg::FLAG_VALID;
		end

		// read data stand only in the cycle after the read strobe
		st_nxt.rdata_r = '0;
		if (i_bus_rd) begin
			unique case (i_bus_addr)
				tef_pkg::ADDR_CTRL: begin
					st_nxt.rdata_r = ctrl_word(st_r.en_r);
				end
				tef_pkg::ADDR_CAPT_MODE: begin
					st_nxt.rdata_r = mode_word(st_r.capt_mode_r);
				end
				tef_pkg::ADDR_INT_MASK: begin
					st_nxt.rdata_r = st_r.mask_r;
				end
				tef_pkg::ADDR_FLAGS: begin
					st_nxt.rdata_r = flag_if.flag;
				end
				default: begin
					if (rd_capt) begin
						st_nxt.rdata_r = 32'(capt_value[32'(capt_idx[1:0]) * CW +: CW]);
					end
				end
			endcase
		end

		// level interrupt, any flag whose mask bit is one
		st_nxt.irq_r = |(flag_if.flag & st_r.mask_r);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_r.en_r        <= 1'b0;
			st_r.capt_mode_r <= tef_pkg::CAPT_MODE_RST;
			st_r.mask_r      <= tef_pkg::MASK_RST;
			st_r.rdata_r     <= 32'h0000_0000;
			st_r.irq_r       <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from flip-flops
	assign o_bus_rdata = st_r.rdata_r;
	assign o_enable    = st_r.en_r;
	assign o_capt_mode = st_r.capt_mode_r;
	assign o_irq       = st_r.irq_r;

endmodule

/* File: tef_pkg.sv */
// constants, field layout and helper functions of the timer event flag block
package tef_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 32;
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_CAPT_MODE = 8'h04;
	localparam logic [7:0]  ADDR_INT_MASK  = 8'h24;
	localparam logic [7:0]  ADDR_FLAGS     = 8'h2C;
	localparam logic [7:0]  ADDR_CAPT_BASE = 8'h44;

	// ------------------------------------------------------------
	// field positions of the event flag register
	// ------------------------------------------------------------
	localparam int          BIT_OVERFLOW   = 0;
	localparam int          BIT_RETRIGGER  = 1;
	localparam int          BIT_COUNT      = 2;
	localparam int          BIT_ERR        = 3;
	localparam int          BIT_UPD_FAULT  = 10;
	localparam int          BIT_DBG_FAULT  = 11;
	localparam int          BIT_FLT_A      = 12;
	localparam int          BIT_FLT_B      = 13;
	localparam int          NRF_LSB        = 14;
	localparam int          NRF_N          = 2;
	localparam int          MC_LSB         = 16;
	localparam int          CH_N           = 4;
	localparam int          CAPT_W         = 24;
	localparam logic [31:0] FLAG_VALID     = 32'h000F_FC0F;

	// control and capture mode register fields
	localparam int          BIT_ENABLE     = 1;
	localparam logic [31:0] CTRL_VALID     = 32'h0000_0002;
	localparam logic [31:0] CAPT_MODE_VALID = 32'h0000_000F;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0] FLAGS_RST      = 32'h0000_0000;
	localparam logic [31:0] MASK_RST       = 32'h0000_0000;
	localparam logic [3:0]  CAPT_MODE_RST  = 4'h0;

	// byte enables widened to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// byte-lane merge of a write into an old value
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = lane_mask(be);
		lane_merge = (old_v & ~m) | (wd & m);
	endfunction

endpackage

/* File: tef_flag_if.sv */
// interface between the register front end and the sticky flag bank
`timescale 1ns/1ns
interface tef_flag_if #(
	parameter int N = 32
);
	logic [N-1:0] set;
	logic [N-1:0] clr;
	logic [N-1:0] flag;

	// flag bank side
	modport bank (
		input  set,
		input  clr,
		output flag
	);

	// controlling side
	modport ctl (
		output set,
		output clr,
		input  flag
	);
endinterface

/* File: tef_flag_bank.sv */
// sticky event flags, set by hardware and cleared by writing one
`timescale 1ns/1ns
module tef_flag_bank #(
	parameter logic [31:0] VALID = tef_pkg::FLAG_VALID
) (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	// set and clear vectors, flag state
	tef_flag_if.bank  fl
);
	typedef struct packed {
		logic [31:0] flag_r;
	} tef_bank_st_t;

	tef_bank_st_t st_r;
	tef_bank_st_t st_nxt;

	// a set in the same cycle as a clear wins
	always_comb begin
		st_nxt        = st_r;
		st_nxt.flag_r = ((st_r.flag_r & ~fl.clr) | fl.set) & VALID;
	end

	// flags register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_r.flag_r <= tef_pkg::FLAGS_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign fl.flag = st_r.flag_r;
endmodule

/* File: tef_capt_store.sv */
// per-channel capture value storage
`timescale 1ns/1ns
module tef_capt_store #(
	parameter int CH = tef_pkg::CH_N,
	parameter int CW = tef_pkg::CAPT_W
) (
	// clock and reset
	input  wire logic            i_core_clk,
	input  wire logic            i_rst,
	// capture inputs
	input  wire logic [CH-1:0]   i_valid,
	input  wire logic [CH*CW-1:0] i_data,
	// stored values
	output logic [CH*CW-1:0]     o_value
);
	typedef struct packed {
		logic [CH*CW-1:0] val_r;
	} tef_capt_st_t;

	tef_capt_st_t st_r;
	tef_capt_st_t st_nxt;

	// load each channel on its own valid strobe
	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < CH; i++) begin
			if (i_valid[i]) begin
				st_nxt.val_r[i*CW +: CW] = i_data[i*CW +: CW];
			end
		end
	end

	// value register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_r.val_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_value = st_r.val_r;
endmodule

/* File: tef_event_flags_props.sv */
// assertions on the ports of the timer event flag block
`timescale 1ns/1ns
module tef_event_flags_props #(
	parameter int CH = tef_pkg::CH_N,
	parameter int CW = tef_pkg::CAPT_W
) (
	// clock and reset
	input wire logic                       i_core_clk,
	input wire logic                       i_rst,
	// register port
	input wire logic [tef_pkg::ADDR_W-1:0] i_bus_addr,
	input wire logic [31:0]                i_bus_wdata,
	input wire logic [3:0]                 i_bus_be,
	input wire logic                       i_bus_wr,
	input wire logic                       i_bus_rd,
	input wire logic [31:0]                o_bus_rdata,
	// events
	input wire logic                       i_overflow_evt,
	input wire logic                       i_retrigger_evt,
	input wire logic                       i_count_evt,
	input wire logic                       i_err_evt,
	input wire logic                       i_upd_fault_evt,
	input wire logic                       i_dbg_fault_evt,
	input wire logic                       i_flt_a_evt,
	input wire logic                       i_flt_b_evt,
	input wire logic [1:0]                 i_nrf_evt,
	input wire logic [CH-1:0]              i_cmp_match,
	input wire logic [CH-1:0]              i_capt_valid,
	input wire logic [CH*CW-1:0]           i_capt_data,
	// status
	input wire logic                       o_enable,
	input wire logic [CH-1:0]              o_capt_mode,
	input wire logic                       o_irq
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	// ------------------------------------------------------------
	// steps: flag read, event then quiet cycle then read
	// ------------------------------------------------------------
	sequence rd_fl;
		i_bus_rd && i_bus_addr == tef_pkg::ADDR_FLAGS;
	endsequence
	sequence ev_rd(e);
		e ##1 !(i_bus_wr || i_bus_rd) ##1 rd_fl;
	endsequence

	AST_RD_IDLE: assert property (!i_bus_rd |=> o_bus_rdata == 32'h0) else $error("rdata not idle");
	AST_RSV_ZERO: assert property (rd_fl |=> (o_bus_rdata & ~tef_pkg::FLAG_VALID) == 32'h0)
		else $error("reserved flag bits set");
	AST_OVERFLOW_SET: assert property (ev_rd(i_overflow_evt) |=> o_bus_rdata[0]) else $error("overflow flag");
	AST_MC_SET: assert property (ev_rd(i_cmp_match[0]) |=> o_bus_rdata[16]) else $error("match flag");
	AST_NRF_SET: assert property (ev_rd(i_nrf_evt[1]) |=> o_bus_rdata[15]) else $error("fault flag");
	AST_FLTB_SET: assert property (ev_rd(i_flt_b_evt) |=> o_bus_rdata[13]) else $error("fault b flag");
	AST_FLTA_SET: assert property (ev_rd(i_flt_a_evt) |=> o_bus_rdata[12]) else $error("fault a flag");
	AST_FLTA_CLR: assert property ((i_bus_wr && i_bus_addr == tef_pkg::ADDR_FLAGS && i_bus_wdata[12] && i_bus_be[1]
		&& !i_flt_a_evt) ##1 !i_flt_a_evt ##1 rd_fl |=> !o_bus_rdata[12]) else $error("fault a clear");
	AST_CAPT_LOCK: assert property (o_enable && i_bus_wr && i_bus_addr == tef_pkg::ADDR_CAPT_MODE
		|=> $stable(o_capt_mode)) else $error("capture mode changed while enabled");
	AST_CAPT_WR: assert property (!o_enable && i_bus_wr && i_bus_addr == tef_pkg::ADDR_CAPT_MODE && i_bus_be[0]
		|=> o_capt_mode == $past(i_bus_wdata[CH-1:0])) else $error("capture mode write lost");
	AST_EN_WR: assert property (i_bus_wr && i_bus_addr == tef_pkg::ADDR_CTRL && i_bus_be[0]
		|=> o_enable == $past(i_bus_wdata[1])) else $error("enable write lost");
endmodule

bind tef_event_flags tef_event_flags_props #(.CH(CH), .CW(CW)) chk_u (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
	.i_bus_be(i_bus_be), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .o_bus_rdata(o_bus_rdata),
	.i_overflow_evt(i_overflow_evt), .i_retrigger_evt(i_retrigger_evt), .i_count_evt(i_count_evt),
	.i_err_evt(i_err_evt), .i_upd_fault_evt(i_upd_fault_evt), .i_dbg_fault_evt(i_dbg_fault_evt),
	.i_flt_a_evt(i_flt_a_evt), .i_flt_b_evt(i_flt_b_evt),
	.i_nrf_evt(i_nrf_evt), .i_cmp_match(i_cmp_match), .i_capt_valid(i_capt_valid), .i_capt_data(i_capt_data),
	.o_enable(o_enable), .o_capt_mode(o_capt_mode), .o_irq(o_irq));

/* File: tef_tb.sv */
// self-checking bench of the timer event flag block
`timescale 1ns/1ns
module testbench;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        i_core_clk   = 1'b0;
	logic        i_rst        = 1'b1;
	logic [7:0]  i_bus_addr   = 8'h00;
	logic [31:0] i_bus_wdata  = 32'h0;
	logic [3:0]  i_bus_be     = 4'h0;
	logic        i_bus_wr     = 1'b0;
	logic        i_bus_rd     = 1'b0;
	logic [31:0] evv          = 32'h0; // event bits, same positions as flags
	logic [3:0]  cv           = 4'h0;
	logic [95:0] cd           = 96'h0;
	logic [31:0] o_bus_rdata;
	logic        o_enable;
	logic [3:0]  o_capt_mode;
	logic        o_irq;
	logic [31:0] d;
	logic [31:0] fe;
	logic [3:0]  b;
	int          err_count    = 0;
	int          total_checks = 0;
	int          cyc          = 0;

	tef_event_flags dut_u (
		.i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
		.i_bus_be(i_bus_be), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .o_bus_rdata(o_bus_rdata),
		.i_overflow_evt(evv[0]), .i_retrigger_evt(evv[1]), .i_count_evt(evv[2]), .i_err_evt(evv[3]),
		.i_upd_fault_evt(evv[10]), .i_dbg_fault_evt(evv[11]), .i_flt_a_evt(evv[12]), .i_flt_b_evt(evv[13]),
		.i_nrf_evt(evv[15:14]), .i_cmp_match(evv[19:16]), .i_capt_valid(cv), .i_capt_data(cd),
		.o_enable(o_enable), .o_capt_mode(o_capt_mode), .o_irq(o_irq));

	// clock and hang guard
	always #2 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc > 5000) begin
			err_count++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// bus tasks, compare and expectation
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] e);
		@(posedge i_core_clk);
		i_bus_addr <= a;
		i_bus_wdata <= v;
		i_bus_be <= e;
		i_bus_wr <= 1'b1;
		@(posedge i_core_clk);
		i_bus_wr <= 1'b0;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_core_clk);
		i_bus_addr <= a;
		i_bus_rd <= 1'b1;
		@(posedge i_core_clk);
		i_bus_rd <= 1'b0;
		#1 d = o_bus_rdata;
		cmp(d, e);
	endtask
	task automatic ev(input logic [31:0] v);
		@(posedge i_core_clk);
		evv <= v;
		@(posedge i_core_clk);
		evv <= 32'h0;
	endtask
	task automatic irq(input logic [31:0] e);
		repeat (3) @(posedge i_core_clk);
		#1 cmp({31'h0, o_irq}, e);
	endtask
	task automatic end_of_test();
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// write-one-clear by selected lanes
	function automatic logic [31:0] w1c(input logic [31:0] f, input logic [31:0] v, input logic [3:0] e);
		w1c = f & ~(v & {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}});
	endfunction

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h5307));
		repeat (20) @(posedge i_core_clk);
		i_rst <= 1'b0;
		// reset values, unmapped address
		chk(8'h2C, 32'h0);
		chk(8'h24, 32'h0);
		chk(8'h04, 32'h0);
		chk(8'h10, 32'h0);
		// each flag: set, write zero, wrong lanes, right lane
		for (int n = 0; n < 20; n++) begin
			if (tef_pkg::FLAG_VALID[n]) begin
				ev(32'h1 << n);
				chk(8'h2C, 32'h1 << n);
				wr(8'h2C, 32'h0, 4'hF);
				wr(8'h2C, 32'h1 << n, ~4'(4'h1 << (n / 8)));
				chk(8'h2C, 32'h1 << n);
				wr(8'h2C, 32'h1 << n, 4'(4'h1 << (n / 8)));
				chk(8'h2C, 32'h0);
			end
		end
		// overflow interrupt gated by its mask bit
		ev(32'h1);
		irq(32'h0);
		wr(8'h24, 32'h1, 4'h1);
		irq(32'h1);
		wr(8'h2C, 32'h1, 4'h1);
		irq(32'h0);
		// capture mode locked while enabled
		wr(8'h04, 32'h5, 4'h1);
		wr(8'h00, 32'h2, 4'h1);
		chk(8'h00, 32'h2);
		wr(8'h04, 32'hA, 4'hF);
		chk(8'h04, 32'h5);
		cmp({27'h0, o_enable, o_capt_mode}, 32'h15);
		wr(8'h00, 32'h0, 4'h1);
		// capture read clears only channels in capture mode
		@(posedge i_core_clk);
		cd <= {$urandom, $urandom, $urandom};
		cv <= 4'hF;
		@(posedge i_core_clk);
		cv <= 4'h0;
		for (int c = 0; c < 4; c++) begin
			chk(8'h44 + 8'(4 * c), {8'h0, cd[c*24 +: 24]});
		end
		chk(8'h2C, 32'h000A_0000);
		wr(8'h2C, 32'hFFFF_FFFF, 4'hF);
		// random events and random lane clears
		fe = 32'h0;
		for (int k = 0; k < 30; k++) begin
			d = $urandom & tef_pkg::FLAG_VALID;
			ev(d);
			fe = fe | d;
			d = $urandom;
			b = 4'($urandom);
			wr(8'h2C, d, b);
			fe = w1c(fe, d, b);
			chk(8'h2C, fe);
		end
		end_of_test();
	end
endmodule
